// ==== oru_pkg.sv ====
package oru_pkg;

   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_IN5_FILT  = 14'h0340;
   localparam logic [13:0] IDX_SPD_CUR   = 14'h034e;
   localparam logic [13:0] IDX_TRQ_CUR   = 14'h034f;
   localparam logic [13:0] IDX_SPD_VOL   = 14'h0350;
   localparam logic [13:0] IDX_TRQ_VOL   = 14'h0351;
   localparam logic [13:0] IDX_COMM_OUT  = 14'h0360;
   localparam logic [13:0] IDX_COMM_ANA  = 14'h0361;
   localparam logic [13:0] IDX_STATUS    = 14'h0362;
   localparam logic [13:0] IDX_O1_FN     = 14'h0400;
   localparam logic [13:0] IDX_O1_POL    = 14'h0401;
   localparam logic [13:0] IDX_O2_FN     = 14'h0402;
   localparam logic [13:0] IDX_O2_POL    = 14'h0403;
   localparam logic [13:0] IDX_SRC_SEL   = 14'h0416;
   localparam logic [13:0] IDX_FORCE     = 14'h0417;
   localparam logic [13:0] IDX_MON_SRC   = 14'h0432;
   localparam logic [13:0] IDX_MON_OFS   = 14'h0433;
   localparam logic [13:0] IDX_MON_GAIN  = 14'h0434;

   // reset values
   localparam logic [15:0] RST_IN5_FILT  = 16'h0032;
   localparam logic [15:0] RST_SPD       = 16'h0bb8;
   localparam logic [15:0] RST_TRQ       = 16'h0064;
   localparam logic [15:0] RST_O1_FN     = 16'h0001;
   localparam logic [15:0] RST_O2_FN     = 16'h000b;
   localparam logic [15:0] RST_ZERO      = 16'h0000;
   localparam logic [15:0] RST_MON_GAIN  = 16'h0064;

   // bit positions
   localparam int BIT_OUT_ONE = 0;
   localparam int BIT_OUT_TWO = 1;
   localparam int BIT_ST_IN5  = 2;
   localparam int BIT_ST_FBOP = 3;

   // output function codes
   localparam logic [15:0] FN_NONE    = 16'h0000;
   localparam logic [15:0] FN_READY   = 16'h0001;
   localparam logic [15:0] FN_ROTATE  = 16'h0002;
   localparam logic [15:0] FN_WARN    = 16'h000a;
   localparam logic [15:0] FN_FAULT   = 16'h000b;
   localparam logic [15:0] FN_COMPARE = 16'h0019;
   localparam logic [15:0] FN_COMM    = 16'h001f;
   localparam logic [15:0] FN_EXTMON  = 16'h0020;

   // analog monitor source codes
   localparam logic [15:0] MON_SPEED   = 16'h0000;
   localparam logic [15:0] MON_SPD_REF = 16'h0001;
   localparam logic [15:0] MON_TRQ_REF = 16'h0002;
   localparam logic [15:0] MON_DEV_REF = 16'h0003;
   localparam logic [15:0] MON_DEV_ENC = 16'h0004;
   localparam logic [15:0] MON_POS_SPD = 16'h0005;
   localparam logic [15:0] MON_POS_DON = 16'h0006;
   localparam logic [15:0] MON_AIN_ONE = 16'h0008;
   localparam logic [15:0] MON_COMM    = 16'h000a;

   // analog scaling
   localparam logic signed [31:0] MON_LIMIT_MV = 32'sh0000_2710;
   localparam logic signed [31:0] GAIN_SCALE   = 32'sh0000_0064;
   localparam logic signed [15:0] POS_DONE_MV  = 16'sh1388;

   // filter timing: setting unit is 0.01 ms
   localparam int CLK_PERIOD_NS = 20;
   localparam int FILT_UNIT_NS  = 10000;
   localparam int FILT_UNIT_CYC =
      (FILT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] FILT_UNIT_LAST = 16'(FILT_UNIT_CYC - 1);

endpackage : oru_pkg

// ==== oru_mon_if.sv ====
`timescale 1ns/100ps
interface oru_mon_if;
   logic        [15:0] srcSel;
   logic signed [15:0] gain;
   logic signed [15:0] offsetMv;
   logic signed [15:0] valueMv;

   modport cfg (output srcSel, output gain, output offsetMv,
                input valueMv);
   modport mon (input srcSel, input gain, input offsetMv,
                output valueMv);
endinterface : oru_mon_if

// ==== oru_debounce.sv ====
`timescale 1ns/100ps
module oru_debounce (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        rawIn,
   input  wire logic [15:0] filtUnits,
   output logic             filtOut
);
   logic [15:0] preCnt_r;
   logic [15:0] unitCnt_r;
   logic        filt_r;
   wire         differs = rawIn != filt_r;
   wire         tick    = preCnt_r == oru_pkg::FILT_UNIT_LAST;
   wire         flip    = differs && (unitCnt_r >= filtUnits);

   assign filtOut = filt_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         preCnt_r  <= 16'h0000;
         unitCnt_r <= 16'h0000;
         filt_r    <= 1'b0;
      end else if (!differs || flip) begin
         preCnt_r  <= 16'h0000;
         unitCnt_r <= 16'h0000;
         filt_r    <= flip ? rawIn : filt_r;
      end else begin
         preCnt_r  <= tick ? 16'h0000 : preCnt_r + 16'h0001;
         unitCnt_r <= tick ? unitCnt_r + 16'h0001 : unitCnt_r;
      end
   end

   default clocking dcb @(posedge clk); endclocking
   default disable iff (rst);

   sequence newEdge;
      differs && filtUnits != 16'h0000 && unitCnt_r == 16'h0000;
   endsequence

   a_filt_zero_pass: assert property (
      filtUnits == 16'h0000 |=> filtOut == $past(rawIn))
      else $error("zero filter time did not pass input through");
   a_filt_hold_new: assert property (
      newEdge |=> $stable(filtOut))
      else $error("filter changed before its time elapsed");
   a_filt_follows: assert property (
      $changed(filtOut) |-> filtOut == $past(rawIn))
      else $error("filter output took a level the input never had");
endmodule : oru_debounce

// ==== oru_monitor.sv ====
`timescale 1ns/100ps
module oru_monitor (
   input  wire logic               clk,
   input  wire logic               rst,
   oru_mon_if.mon                  mon,
   input  wire logic signed [15:0] motorSpeed,
   input  wire logic signed [15:0] speedRef,
   input  wire logic signed [15:0] torqueRef,
   input  wire logic signed [15:0] posDevRef,
   input  wire logic signed [15:0] posDevEnc,
   input  wire logic signed [15:0] posRefSpeed,
   input  wire logic               posDone,
   input  wire logic signed [15:0] analogInOne,
   input  wire logic signed [15:0] commAnalog
);
   logic signed [15:0] selVal;
   logic signed [15:0] value_r;
   logic signed [31:0] prod;
   logic signed [31:0] sum;
   logic signed [15:0] value_nxt;

   always_comb begin
      if (mon.srcSel == oru_pkg::MON_SPEED) selVal = motorSpeed;
      else if (mon.srcSel == oru_pkg::MON_SPD_REF) selVal = speedRef;
      else if (mon.srcSel == oru_pkg::MON_TRQ_REF) selVal = torqueRef;
      else if (mon.srcSel == oru_pkg::MON_DEV_REF) selVal = posDevRef >>> 1;
      else if (mon.srcSel == oru_pkg::MON_DEV_ENC) selVal = posDevEnc >>> 1;
      else if (mon.srcSel == oru_pkg::MON_POS_SPD) selVal = posRefSpeed;
      else if (mon.srcSel == oru_pkg::MON_POS_DON)
         selVal = posDone ? oru_pkg::POS_DONE_MV : 16'sh0000;
      else if (mon.srcSel == oru_pkg::MON_AIN_ONE) selVal = analogInOne;
      else if (mon.srcSel == oru_pkg::MON_COMM) selVal = commAnalog;
      else selVal = 16'sh0000;
   end

   always_comb begin
      prod = (32'(selVal) * 32'(mon.gain)) / oru_pkg::GAIN_SCALE;
      sum  = prod + 32'(mon.offsetMv);
      if (sum > oru_pkg::MON_LIMIT_MV)
         value_nxt = 16'(oru_pkg::MON_LIMIT_MV);
      else if (sum < -oru_pkg::MON_LIMIT_MV)
         value_nxt = 16'(-oru_pkg::MON_LIMIT_MV);
      else value_nxt = 16'(sum);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) value_r <= 16'sh0000;
      else value_r <= value_nxt;
   end
   assign mon.valueMv = value_r;

   default clocking dcb @(posedge clk); endclocking
   default disable iff (rst);

   a_mon_unity: assert property (
      (mon.srcSel == oru_pkg::MON_SPEED && mon.gain == 16'sh0064
       && mon.offsetMv == 16'sh0000 && motorSpeed <= 16'sh2710
       && motorSpeed >= -16'sh2710)
      |=> mon.valueMv == $past(motorSpeed))
      else $error("unity monitor path does not show motor speed");
   a_mon_limit: assert property (
      mon.valueMv <= 16'sh2710 && mon.valueMv >= -16'sh2710)
      else $error("monitor value outside its voltage range");
   a_mon_offset: assert property (
      (mon.gain == 16'sh0000 && mon.offsetMv == 16'sh03e8)
      |=> mon.valueMv == 16'sh03e8)
      else $error("offset not applied with zero gain");
endmodule : oru_monitor

// ==== oru_top.sv ====
`timescale 1ns/100ps
// Function
// - function code picks the output source
// - polarity bit inverts the selected level
// - source bit picks function or comm bit
// - non-operational fieldbus forces chosen outputs inactive
// - input five debounced, time applied at once
// - monitor source code selects monitored quantity
// - monitor value scaled by gain, then offset
module oru_top (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic [15:0]        wbAdr,
   input  wire logic [31:0]        wbDatI,
   output logic      [31:0]        wbDatO,
   input  wire logic               wbWe,
   input  wire logic [3:0]         wbSel,
   input  wire logic               wbCyc,
   input  wire logic               wbStb,
   output logic                    wbAck,
   input  wire logic               fieldbusOperational,
   input  wire logic               driveReady,
   input  wire logic               motorRotating,
   input  wire logic               warning,
   input  wire logic               fault,
   input  wire logic               compareResult,
   input  wire logic               extDevMonitor,
   input  wire logic               inputFiveRaw,
   output logic                    inputFiveFiltered,
   output logic                    outputOne,
   output logic                    outputTwo,
   input  wire logic signed [15:0] motorSpeed,
   input  wire logic signed [15:0] speedRef,
   input  wire logic signed [15:0] torqueRef,
   input  wire logic signed [15:0] posDevRef,
   input  wire logic signed [15:0] posDevEnc,
   input  wire logic signed [15:0] posRefSpeed,
   input  wire logic               posDone,
   input  wire logic signed [15:0] analogInOne,
   output logic signed [15:0]      analogMonitorMv
);

   // byte-lane merge of the low half word
   function automatic logic [15:0] mergeLow(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
      mergeLow = {sel[1] ? dat[15:8] : old[15:8],
                  sel[0] ? dat[7:0]  : old[7:0]};
   endfunction : mergeLow

   // function level of one output
   function automatic logic fnLevel(input logic [15:0] code,
                                    input logic        commBit,
                                    input logic [5:0]  st);
      if (code == oru_pkg::FN_READY) fnLevel = st[0];
      else if (code == oru_pkg::FN_ROTATE) fnLevel = st[1];
      else if (code == oru_pkg::FN_WARN) fnLevel = st[2];
      else if (code == oru_pkg::FN_FAULT) fnLevel = st[3];
      else if (code == oru_pkg::FN_COMPARE) fnLevel = st[4];
      else if (code == oru_pkg::FN_COMM) fnLevel = commBit;
      else if (code == oru_pkg::FN_EXTMON) fnLevel = st[5];
      else fnLevel = 1'b0;
   endfunction : fnLevel

   logic [15:0] filt_r;
   logic [15:0] spdCur_r;
   logic [15:0] trqCur_r;
   logic [15:0] spdVol_r;
   logic [15:0] trqVol_r;
   logic [15:0] commOut_r;
   logic [15:0] commAna_r;
   logic [15:0] o1Fn_r;
   logic [15:0] o1Pol_r;
   logic [15:0] o2Fn_r;
   logic [15:0] o2Pol_r;
   logic [15:0] srcSel_r;
   logic [15:0] force_r;
   logic [15:0] monSrc_r;
   logic [15:0] monOfs_r;
   logic [15:0] monGain_r;
   logic        ack_r;
   logic [31:0] datO_r;
   logic [31:0] datO_nxt;
   logic        out1_r;
   logic        out2_r;

   oru_mon_if monBus ();

   // bus decode
   wire [13:0] idx     = wbAdr[15:2];
   wire        req     = wbCyc && wbStb && !ack_r;
   // writes land on the acknowledged edge
   wire        wr      = wbCyc && wbStb && wbWe && ack_r;
   wire [5:0]  status  = {extDevMonitor, compareResult, fault,
                          warning, motorRotating, driveReady};
   wire [15:0] stWord  = {12'h000, fieldbusOperational,
                          inputFiveFiltered, out2_r, out1_r};

   wire wrFilt    = wr && idx == oru_pkg::IDX_IN5_FILT;
   wire wrSpdCur  = wr && idx == oru_pkg::IDX_SPD_CUR;
   wire wrTrqCur  = wr && idx == oru_pkg::IDX_TRQ_CUR;
   wire wrSpdVol  = wr && idx == oru_pkg::IDX_SPD_VOL;
   wire wrTrqVol  = wr && idx == oru_pkg::IDX_TRQ_VOL;
   wire wrCommOut = wr && idx == oru_pkg::IDX_COMM_OUT;
   wire wrCommAna = wr && idx == oru_pkg::IDX_COMM_ANA;
   wire wrO1Fn    = wr && idx == oru_pkg::IDX_O1_FN;
   wire wrO1Pol   = wr && idx == oru_pkg::IDX_O1_POL;
   wire wrO2Fn    = wr && idx == oru_pkg::IDX_O2_FN;
   wire wrO2Pol   = wr && idx == oru_pkg::IDX_O2_POL;
   wire wrSrcSel  = wr && idx == oru_pkg::IDX_SRC_SEL;
   wire wrForce   = wr && idx == oru_pkg::IDX_FORCE;
   wire wrMonSrc  = wr && idx == oru_pkg::IDX_MON_SRC;
   wire wrMonOfs  = wr && idx == oru_pkg::IDX_MON_OFS;
   wire wrMonGain = wr && idx == oru_pkg::IDX_MON_GAIN;

   // read mux, unmapped reads zero
   always_comb begin
      if (idx == oru_pkg::IDX_IN5_FILT) datO_nxt = {16'h0000, filt_r};
      else if (idx == oru_pkg::IDX_SPD_CUR) datO_nxt = {16'h0000, spdCur_r};
      else if (idx == oru_pkg::IDX_TRQ_CUR) datO_nxt = {16'h0000, trqCur_r};
      else if (idx == oru_pkg::IDX_SPD_VOL) datO_nxt = {16'h0000, spdVol_r};
      else if (idx == oru_pkg::IDX_TRQ_VOL) datO_nxt = {16'h0000, trqVol_r};
      else if (idx == oru_pkg::IDX_COMM_OUT) datO_nxt = {16'h0000, commOut_r};
      else if (idx == oru_pkg::IDX_COMM_ANA) datO_nxt = {16'h0000, commAna_r};
      else if (idx == oru_pkg::IDX_STATUS) datO_nxt = {16'h0000, stWord};
      else if (idx == oru_pkg::IDX_O1_FN) datO_nxt = {16'h0000, o1Fn_r};
      else if (idx == oru_pkg::IDX_O1_POL) datO_nxt = {16'h0000, o1Pol_r};
      else if (idx == oru_pkg::IDX_O2_FN) datO_nxt = {16'h0000, o2Fn_r};
      else if (idx == oru_pkg::IDX_O2_POL) datO_nxt = {16'h0000, o2Pol_r};
      else if (idx == oru_pkg::IDX_SRC_SEL) datO_nxt = {16'h0000, srcSel_r};
      else if (idx == oru_pkg::IDX_FORCE) datO_nxt = {16'h0000, force_r};
      else if (idx == oru_pkg::IDX_MON_SRC) datO_nxt = {16'h0000, monSrc_r};
      else if (idx == oru_pkg::IDX_MON_OFS) datO_nxt = {16'h0000, monOfs_r};
      else if (idx == oru_pkg::IDX_MON_GAIN) datO_nxt = {16'h0000, monGain_r};
      else datO_nxt = 32'h0000_0000;
   end

   // bus answer one cycle after request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_r  <= 1'b0;
         datO_r <= 32'h0000_0000;
      end else begin
         ack_r  <= req;
         datO_r <= (req && !wbWe) ? datO_nxt : datO_r;
      end
   end
   assign wbAck  = ack_r;
   assign wbDatO = datO_r;

   // filter time written takes effect at once
   always_ff @(posedge clk or posedge rst) begin
      if (rst) filt_r <= oru_pkg::RST_IN5_FILT;
      else if (wrFilt) filt_r <= mergeLow(filt_r, wbDatI, wbSel);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spdCur_r  <= oru_pkg::RST_SPD;
         trqCur_r  <= oru_pkg::RST_TRQ;
         spdVol_r  <= oru_pkg::RST_SPD;
         trqVol_r  <= oru_pkg::RST_TRQ;
         commOut_r <= oru_pkg::RST_ZERO;
         commAna_r <= oru_pkg::RST_ZERO;
      end else begin
         if (wrSpdCur) spdCur_r <= mergeLow(spdCur_r, wbDatI, wbSel);
         if (wrTrqCur) trqCur_r <= mergeLow(trqCur_r, wbDatI, wbSel);
         if (wrSpdVol) spdVol_r <= mergeLow(spdVol_r, wbDatI, wbSel);
         if (wrTrqVol) trqVol_r <= mergeLow(trqVol_r, wbDatI, wbSel);
         if (wrCommOut) commOut_r <= mergeLow(commOut_r, wbDatI, wbSel);
         if (wrCommAna) commAna_r <= mergeLow(commAna_r, wbDatI, wbSel);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         o1Fn_r   <= oru_pkg::RST_O1_FN;
         o1Pol_r  <= oru_pkg::RST_ZERO;
         o2Fn_r   <= oru_pkg::RST_O2_FN;
         o2Pol_r  <= oru_pkg::RST_ZERO;
         srcSel_r <= oru_pkg::RST_ZERO;
         force_r  <= oru_pkg::RST_ZERO;
      end else begin
         if (wrO1Fn) o1Fn_r <= mergeLow(o1Fn_r, wbDatI, wbSel);
         if (wrO1Pol) o1Pol_r <= mergeLow(o1Pol_r, wbDatI, wbSel);
         if (wrO2Fn) o2Fn_r <= mergeLow(o2Fn_r, wbDatI, wbSel);
         if (wrO2Pol) o2Pol_r <= mergeLow(o2Pol_r, wbDatI, wbSel);
         if (wrSrcSel) srcSel_r <= mergeLow(srcSel_r, wbDatI, wbSel);
         if (wrForce) force_r <= mergeLow(force_r, wbDatI, wbSel);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         monSrc_r  <= oru_pkg::RST_ZERO;
         monOfs_r  <= oru_pkg::RST_ZERO;
         monGain_r <= oru_pkg::RST_MON_GAIN;
      end else begin
         if (wrMonSrc) monSrc_r <= mergeLow(monSrc_r, wbDatI, wbSel);
         if (wrMonOfs) monOfs_r <= mergeLow(monOfs_r, wbDatI, wbSel);
         if (wrMonGain) monGain_r <= mergeLow(monGain_r, wbDatI, wbSel);
      end
   end

   wire fnOne  = fnLevel(o1Fn_r, commOut_r[oru_pkg::BIT_OUT_ONE], status);
   wire fnTwo  = fnLevel(o2Fn_r, commOut_r[oru_pkg::BIT_OUT_TWO], status);
   wire selOne = srcSel_r[oru_pkg::BIT_OUT_ONE]
                 ? commOut_r[oru_pkg::BIT_OUT_ONE] : fnOne;
   wire selTwo = srcSel_r[oru_pkg::BIT_OUT_TWO]
                 ? commOut_r[oru_pkg::BIT_OUT_TWO] : fnTwo;
   wire polOne = selOne ^ o1Pol_r[0];
   wire polTwo = selTwo ^ o2Pol_r[0];
   wire frcOne = !fieldbusOperational && force_r[oru_pkg::BIT_OUT_ONE];
   wire frcTwo = !fieldbusOperational && force_r[oru_pkg::BIT_OUT_TWO];
   // forced output at inactive physical level
   wire out1_nxt = frcOne ? o1Pol_r[0] : polOne;
   wire out2_nxt = frcTwo ? o2Pol_r[0] : polTwo;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out1_r <= 1'b0;
         out2_r <= 1'b0;
      end else begin
         out1_r <= out1_nxt;
         out2_r <= out2_nxt;
      end
   end
   assign outputOne = out1_r;
   assign outputTwo = out2_r;

   assign monBus.srcSel   = monSrc_r;
   assign monBus.gain     = monGain_r;
   assign monBus.offsetMv = monOfs_r;
   assign analogMonitorMv = monBus.valueMv;

   oru_monitor uMon (
      .clk         (clk),
      .rst         (rst),
      .mon         (monBus.mon),
      .motorSpeed  (motorSpeed),
      .speedRef    (speedRef),
      .torqueRef   (torqueRef),
      .posDevRef   (posDevRef),
      .posDevEnc   (posDevEnc),
      .posRefSpeed (posRefSpeed),
      .posDone     (posDone),
      .analogInOne (analogInOne),
      .commAnalog  (commAna_r)
   );

   oru_debounce uDeb (
      .clk       (clk),
      .rst       (rst),
      .rawIn     (inputFiveRaw),
      .filtUnits (filt_r),
      .filtOut   (inputFiveFiltered)
   );

   default clocking dcb @(posedge clk); endclocking
   default disable iff (rst);

   sequence forceHeld;
      (!fieldbusOperational && force_r[1] && o2Pol_r[0])[*3];
   endsequence

   a_fn_none_low: assert property (
      (o1Fn_r == oru_pkg::FN_NONE && !srcSel_r[0] && !o1Pol_r[0]
       && !frcOne) |=> !outputOne)
      else $error("unassigned output one not low");
   a_fault_route: assert property (
      (o2Fn_r == oru_pkg::FN_FAULT && !srcSel_r[1] && !o2Pol_r[0]
       && !frcTwo) |=> outputTwo == $past(fault))
      else $error("output two does not follow fault");
   a_pol_invert: assert property (
      (o1Fn_r == oru_pkg::FN_READY && !srcSel_r[0] && o1Pol_r[0]
       && !frcOne) |=> outputOne != $past(driveReady))
      else $error("inverted output one equals ready level");
   a_src_comm: assert property (
      (srcSel_r[1] && !frcTwo)
      |=> outputTwo == ($past(commOut_r[1]) ^ $past(o2Pol_r[0])))
      else $error("output two ignores communication bit");
   a_force_off: assert property (
      frcOne |=> outputOne == $past(o1Pol_r[0]))
      else $error("forced output one not inactive");
   a_force_order: assert property (
      forceHeld |-> outputTwo && $past(outputTwo))
      else $error("forced inverted output two not at inactive level");
   a_ack_single: assert property (
      wbAck |=> !wbAck)
      else $error("acknowledge held longer than one cycle");
   a_ack_answer: assert property (
      (wbCyc && wbStb && !wbAck) |=> wbAck)
      else $error("request not acknowledged in the next cycle");
   a_rd_upper_zero: assert property (
      wbDatO[31:16] == 16'h0000)
      else $error("upper read data half not zero");
endmodule : oru_top

// ==== oru_far_model.sv ====
`timescale 1ns/100ps
// relay and status side of the drive outputs
module oru_far_model (
   input  wire logic [5:0] stat,
   input  wire logic       outputOne,
   input  wire logic       outputTwo,
   output logic            driveReady,
   output logic            motorRotating,
   output logic            warning,
   output logic            fault,
   output logic            compareResult,
   output logic            extDevMonitor,
   output logic [1:0]      contacts
);
   assign driveReady    = stat[0];
   assign motorRotating = stat[1];
   assign warning       = stat[2];
   assign fault         = stat[3];
   assign compareResult = stat[4];
   assign extDevMonitor = stat[5];
   // relay contacts, 1 = closed
   assign contacts      = {outputTwo, outputOne};
endmodule : oru_far_model

// ==== tb_output_routing_unit.sv ====
`timescale 1ns/100ps
module tb_output_routing_unit;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic        [15:0] wbAdr = 16'h0000;
   logic        [31:0] wbDatI = 32'h0;
   logic        [31:0] wbDatO;
   logic               wbWe = 1'b0;
   logic        [3:0]  wbSel = 4'h0;
   logic               wbCyc = 1'b0;
   logic               wbStb = 1'b0;
   logic               wbAck;
   logic               fbOp = 1'b1;
   logic        [5:0]  stat = 6'h00;
   logic               raw = 1'b0;
   logic               filt;
   logic               o1;
   logic               o2;
   logic               dr, mr, wn, ft, cr, ed;
   logic        [1:0]  seen;
   logic signed [15:0] monMv;
   logic        [15:0] rdq;
   logic signed [15:0] spd = 16'sh0011;
   logic signed [15:0] ain = 16'sh0088;
   logic               pDone = 1'b1;
   int                 nMismatch = 0;
   int                 numChecks = 0;
   logic [15:0] fnC [7] = '{16'h0, 16'h1, 16'h2, 16'ha, 16'hb, 16'h19, 16'h20};
   int          fnB [7] = '{0, 0, 1, 2, 3, 4, 5};
   logic [15:0] mC [8] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h6,
                           16'h8};
   logic [15:0] mE [8] = '{16'h11, 16'h22, 16'h33, 16'h20, 16'h30, 16'h55,
                           16'h1388, 16'h88};

   always #10 clk = ~clk;

   oru_far_model oru_far_model_i (.stat(stat), .outputOne(o1),
      .outputTwo(o2), .driveReady(dr), .motorRotating(mr), .warning(wn),
      .fault(ft), .compareResult(cr), .extDevMonitor(ed), .contacts(seen));

   oru_top oru_top_i (.clk(clk), .rst(rst), .wbAdr(wbAdr), .wbDatI(wbDatI),
      .wbDatO(wbDatO), .wbWe(wbWe), .wbSel(wbSel), .wbCyc(wbCyc),
      .wbStb(wbStb), .wbAck(wbAck), .fieldbusOperational(fbOp),
      .driveReady(dr), .motorRotating(mr), .warning(wn), .fault(ft),
      .compareResult(cr), .extDevMonitor(ed), .inputFiveRaw(raw),
      .inputFiveFiltered(filt), .outputOne(o1), .outputTwo(o2),
      .motorSpeed(spd), .speedRef(16'sh0022), .torqueRef(16'sh0033),
      .posDevRef(16'sh0040), .posDevEnc(16'sh0060), .posRefSpeed(16'sh0055),
      .posDone(pDone), .analogInOne(ain), .analogMonitorMv(monMv));

   task automatic final_report();
      $display("checks=%0d mismatches=%0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      numChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // classic single cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [13:0] a,
                      input logic [15:0] d);
      @(posedge clk);
      wbAdr <= {a, 2'b00};
      wbDatI <= {16'h0000, d};
      wbWe <= w;
      wbSel <= 4'h3;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      do @(posedge clk); while (wbAck !== 1'b1);
      rdq = wbDatO[15:0];
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask : bus

   task automatic wr(input logic [13:0] a, input logic [15:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [13:0] a, input logic [15:0] e);
      bus(1'b0, a, 16'h0);
      chk(rdq, e);
   endtask : rd

   task automatic out(input int b, input logic e);
      repeat (2) @(posedge clk);
      chk({15'h0, seen[b]}, {15'h0, e});
   endtask : out

   task automatic mon(input logic [15:0] e);
      repeat (2) @(posedge clk);
      chk(monMv, e);
   endtask : mon

   initial begin
      repeat (20000) @(posedge clk);
      nMismatch++;
      final_report();
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(oru_pkg::IDX_O1_FN, 16'h0001);
      rd(oru_pkg::IDX_O2_FN, 16'h000b);
      rd(oru_pkg::IDX_FORCE, 16'h0000);
      rd(oru_pkg::IDX_SPD_CUR, 16'h0bb8);
      rd(14'h0100, 16'h0000);
      stat <= 6'h08;
      out(1, 1'b1);
      for (int i = 0; i < 7; i++) begin
         wr(oru_pkg::IDX_O1_FN, fnC[i]);
         stat <= 6'h01 << fnB[i];
         out(0, i != 0);
         stat <= ~(6'h01 << fnB[i]);
         out(0, 1'b0);
      end
      wr(oru_pkg::IDX_COMM_OUT, 16'h0001);
      wr(oru_pkg::IDX_O1_FN, oru_pkg::FN_COMM);
      out(0, 1'b1);
      wr(oru_pkg::IDX_O1_FN, oru_pkg::FN_READY);
      stat <= 6'h01;
      wr(oru_pkg::IDX_O1_POL, 16'h0001);
      out(0, 1'b0);
      stat <= 6'h00;
      out(0, 1'b1);
      wr(oru_pkg::IDX_SRC_SEL, 16'h0003);
      wr(oru_pkg::IDX_COMM_OUT, 16'h0003);
      out(0, 1'b0);
      out(1, 1'b1);
      fbOp <= 1'b0;
      out(1, 1'b1);
      wr(oru_pkg::IDX_FORCE, 16'h0001);
      out(0, 1'b1);
      out(1, 1'b1);
      wr(oru_pkg::IDX_FORCE, 16'h0002);
      out(0, 1'b0);
      out(1, 1'b0);
      fbOp <= 1'b1;
      out(1, 1'b1);
      wr(oru_pkg::IDX_O2_POL, 16'h0001);
      fbOp <= 1'b0;
      out(1, 1'b1);
      out(1, 1'b1);
      fbOp <= 1'b1;
      out(1, 1'b0);
      rd(oru_pkg::IDX_IN5_FILT, 16'h0032);
      wr(oru_pkg::IDX_IN5_FILT, 16'h0000);
      raw <= 1'b1;
      repeat (3) @(posedge clk);
      chk({15'h0, filt}, 16'h0001);
      rd(oru_pkg::IDX_STATUS, 16'h000c);
      wr(oru_pkg::IDX_IN5_FILT, 16'h0001);
      raw <= 1'b0;
      repeat (400) @(posedge clk);
      chk({15'h0, filt}, 16'h0001);
      repeat (150) @(posedge clk);
      chk({15'h0, filt}, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         wr(oru_pkg::IDX_MON_SRC, mC[i]);
         mon(mE[i]);
      end
      pDone <= 1'b0;
      ain <= 16'shf000;
      spd <= 16'sh2328;
      wr(oru_pkg::IDX_MON_SRC, oru_pkg::MON_POS_DON);
      mon(16'h0000);
      wr(oru_pkg::IDX_MON_SRC, oru_pkg::MON_AIN_ONE);
      mon(16'hf000);
      wr(oru_pkg::IDX_MON_SRC, oru_pkg::MON_SPEED);
      mon(16'h2328);
      wr(oru_pkg::IDX_COMM_ANA, 16'h04d2);
      wr(oru_pkg::IDX_MON_GAIN, 16'h00c8);
      wr(oru_pkg::IDX_MON_OFS, 16'hff9c);
      wr(oru_pkg::IDX_MON_SRC, oru_pkg::MON_COMM);
      mon(16'h0940);
      wr(oru_pkg::IDX_MON_GAIN, 16'h270f);
      mon(16'h2710);
      wr(oru_pkg::IDX_MON_GAIN, 16'hd8f1);
      mon(16'hd8f0);
      wr(oru_pkg::IDX_MON_GAIN, 16'h0000);
      wr(oru_pkg::IDX_MON_OFS, 16'h03e8);
      mon(16'h03e8);
      final_report();
   end
endmodule : tb_output_routing_unit
